// ==== hdl/irb_pkg.sv ====
package irb_pkg;
  // ==========================================================================
  // Register offsets
  localparam logic [7:0] ADDR_CTRL  = 8'hA0;
  localparam logic [7:0] ADDR_RSV   = 8'hA1;
  localparam logic [7:0] ADDR_SLOOP = 8'hA2;
  localparam logic [7:0] ADDR_SGAP  = 8'hA3;
  localparam logic [7:0] ADDR_PLOOP = 8'hA4;
  localparam logic [7:0] ADDR_PGAP  = 8'hA5;
  localparam logic [7:0] ADDR_BT    = 8'hA6;
  localparam logic [7:0] ADDR_SLEN  = 8'hA7;
  localparam logic [7:0] ADDR_STAT  = 8'hA8;

  // ==========================================================================
  // Field positions
  localparam int IRQ_EN_BIT = 5;
  localparam int SLEW_BIT   = 4;
  localparam int QZL_BIT    = 3;
  localparam int QZT_MSB    = 2;
  localparam int BT_MSB     = 5;
  localparam int DONE_BIT   = 1;
  localparam int BUSY_BIT   = 0;

  // ==========================================================================
  // Timing
  localparam int CLK_PERIOD_PS = 10000;
  localparam int BIT_UNIT_PS   = 270000;
  localparam int UNIT_CYC      = BIT_UNIT_PS / CLK_PERIOD_PS;
  localparam int SGAP_MULT     = 2;
  localparam int PGAP_MULT     = 4;
  localparam int NIBBLE_BITS   = 4;
  localparam int CNT_W         = 11;
  localparam int ADDR_W        = 10;

  typedef struct packed {
    logic       irq_en;
    logic       slew;
    logic       qz_level;
    logic [2:0] qz_len;
    logic [7:0] sym_loops;
    logic [7:0] sym_gap;
    logic [7:0] pkt_loops;
    logic [7:0] pkt_gap;
    logic [5:0] bt_code;
    logic [7:0] nibbles;
  } irb_cfg_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_QZ_LEAD, ST_PATTERN, ST_QZ_TRAIL, ST_SYM_GAP, ST_PKT_GAP
  } irb_state_t;
endpackage : irb_pkg

// ==== hdl/irb_burst_timing.sv ====
// Notes on behaviour
// - Control byte writes act only while burst mode enable is high.
// - Interrupt output asserts only while control bit 5 is set.
// - Quiet level high with nonzero length: zero pattern bits drive low.
// - Quiet zone of 2*2^code+1 bit-times before and after each symbol for nonzero code; code 0 gives none.
// - During quiet zones the LED output holds the quiet level.
// - Symbol sent symbol-loop count plus one times.
// - LED off 2*(symbol gap+1) bit-times between symbol loops.
// - Packet repeated packet-loop count plus one times.
// - LED off 4*(packet gap+1) bit-times between packets.
// - Bit-time is (code+1) times 0.27 us; all timing uses it.
// - Length byte gives nibbles minus one; a write to it with burst mode enable high starts an event.
// - Done flag set at event end; busy flag while transmitting.
`timescale 1ns/100ps
module irb_burst_timing (
  input  wire logic                      ref_clk,          // Core clock
  input  wire logic                      nrst,             // Async reset
  input  wire logic                      burst_mode_enable,// Burst mode on
  input  wire logic [7:0]                reg_addr,         // Register offset
  input  wire logic [7:0]                reg_wdata,        // Write data
  input  wire logic                      reg_wr,           // Write strobe
  output logic      [7:0]                reg_rdata,        // Read data
  input  wire logic                      done_clear,       // Clears done
  input  wire logic                      pattern_bit,      // Bit at address
  output logic      [irb_pkg::ADDR_W-1:0] pattern_addr,    // Pattern address
  output logic                           led_drive_out,    // LED level
  output logic                           led_drive_oe_n,   // Low = driving
  output logic                           burst_irq         // Done interrupt
);
  // ==========================================================================
  // Configuration
  irb_pkg::irb_cfg_t          cfg_r;
  logic [7:0]                 rsv_r;
  irb_pkg::irb_state_t        state_r;
  logic [irb_pkg::CNT_W-1:0]  cnt_r;
  logic [7:0]                 sloop_r;
  logic [7:0]                 ploop_r;
  logic [5:0]                 unit_r;
  logic [5:0]                 mult_r;
  logic                       done_r;
  logic                       bit_tick;
  logic                       start;
  logic                       fin;
  logic                       wr_ok;

  function automatic logic [irb_pkg::CNT_W-1:0] qz_last(input logic [2:0] c);
    qz_last = irb_pkg::CNT_W'(2) << c;
  endfunction : qz_last

  assign wr_ok = reg_wr && burst_mode_enable;
  assign start = wr_ok && (reg_addr == irb_pkg::ADDR_SLEN);

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cfg_r <= '0;
      rsv_r <= 8'h00;
    end else if (wr_ok) begin
      case (reg_addr)
        irb_pkg::ADDR_CTRL: begin
          cfg_r.irq_en   <= reg_wdata[irb_pkg::IRQ_EN_BIT];
          cfg_r.slew     <= reg_wdata[irb_pkg::SLEW_BIT];
          cfg_r.qz_level <= reg_wdata[irb_pkg::QZL_BIT];
          cfg_r.qz_len   <= reg_wdata[irb_pkg::QZT_MSB:0];
        end
        irb_pkg::ADDR_RSV:   rsv_r           <= reg_wdata;
        irb_pkg::ADDR_SLOOP: cfg_r.sym_loops <= reg_wdata;
        irb_pkg::ADDR_SGAP:  cfg_r.sym_gap   <= reg_wdata;
        irb_pkg::ADDR_PLOOP: cfg_r.pkt_loops <= reg_wdata;
        irb_pkg::ADDR_PGAP:  cfg_r.pkt_gap   <= reg_wdata;
        irb_pkg::ADDR_BT:    cfg_r.bt_code   <= reg_wdata[irb_pkg::BT_MSB:0];
        irb_pkg::ADDR_SLEN:  cfg_r.nibbles   <= reg_wdata;
        default: ;
      endcase
    end
  end

  // ==========================================================================
  // Read-back
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
    end else begin
      case (reg_addr)
        irb_pkg::ADDR_CTRL:  reg_rdata <= {2'b00, cfg_r.irq_en, cfg_r.slew,
                                           cfg_r.qz_level, cfg_r.qz_len};
        irb_pkg::ADDR_RSV:   reg_rdata <= rsv_r;
        irb_pkg::ADDR_SLOOP: reg_rdata <= cfg_r.sym_loops;
        irb_pkg::ADDR_SGAP:  reg_rdata <= cfg_r.sym_gap;
        irb_pkg::ADDR_PLOOP: reg_rdata <= cfg_r.pkt_loops;
        irb_pkg::ADDR_PGAP:  reg_rdata <= cfg_r.pkt_gap;
        irb_pkg::ADDR_BT:    reg_rdata <= {2'b00, cfg_r.bt_code};
        irb_pkg::ADDR_SLEN:  reg_rdata <= cfg_r.nibbles;
        irb_pkg::ADDR_STAT:  reg_rdata <= {6'h00, done_r,
                                           state_r != irb_pkg::ST_IDLE};
        default:             reg_rdata <= 8'h00;
      endcase
    end
  end

  // ==========================================================================
  // Bit-time base
  // Unit times code plus one
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      unit_r <= '0;
      mult_r <= '0;
    end else if (start || state_r == irb_pkg::ST_IDLE) begin
      unit_r <= '0;
      mult_r <= '0;
    end else if (unit_r == 6'(irb_pkg::UNIT_CYC - 1)) begin
      unit_r <= '0;
      mult_r <= (mult_r == cfg_r.bt_code) ? 6'h00 : mult_r + 6'h01;
    end else begin
      unit_r <= unit_r + 6'h01;
    end
  end

  assign bit_tick = (unit_r == 6'(irb_pkg::UNIT_CYC - 1))
                    && (mult_r == cfg_r.bt_code);

  // ==========================================================================
  // Sequencer
  logic [irb_pkg::CNT_W-1:0] last;
  always_comb begin
    case (state_r)
      irb_pkg::ST_QZ_LEAD, irb_pkg::ST_QZ_TRAIL: last = qz_last(cfg_r.qz_len);
      irb_pkg::ST_PATTERN: last = irb_pkg::CNT_W'(irb_pkg::NIBBLE_BITS
                                  * (int'(cfg_r.nibbles) + 1) - 1);
      irb_pkg::ST_SYM_GAP: last = irb_pkg::CNT_W'(irb_pkg::SGAP_MULT
                                  * (int'(cfg_r.sym_gap) + 1) - 1);
      irb_pkg::ST_PKT_GAP: last = irb_pkg::CNT_W'(irb_pkg::PGAP_MULT
                                  * (int'(cfg_r.pkt_gap) + 1) - 1);
      default:             last = '0;
    endcase
  end

  logic phase_end;
  logic qz_on;
  assign phase_end = bit_tick && (cnt_r == last);
  assign qz_on     = cfg_r.qz_len != 3'b000;
  assign fin       = phase_end && (state_r == irb_pkg::ST_QZ_TRAIL
                     || (state_r == irb_pkg::ST_PATTERN && !qz_on))
                     && sloop_r == cfg_r.sym_loops
                     && ploop_r == cfg_r.pkt_loops;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= irb_pkg::ST_IDLE;
      cnt_r   <= '0;
      sloop_r <= 8'h00;
      ploop_r <= 8'h00;
    end else if (!burst_mode_enable) begin
      state_r <= irb_pkg::ST_IDLE;
    end else if (start) begin
      state_r <= qz_on ? irb_pkg::ST_QZ_LEAD : irb_pkg::ST_PATTERN;
      cnt_r   <= '0;
      sloop_r <= 8'h00;
      ploop_r <= 8'h00;
    end else if (phase_end) begin
      cnt_r <= '0;
      case (state_r)
        irb_pkg::ST_QZ_LEAD: state_r <= irb_pkg::ST_PATTERN;
        irb_pkg::ST_PATTERN, irb_pkg::ST_QZ_TRAIL: begin
          if (state_r == irb_pkg::ST_PATTERN && qz_on) begin
            state_r <= irb_pkg::ST_QZ_TRAIL;
          end else if (sloop_r != cfg_r.sym_loops) begin
            sloop_r <= sloop_r + 8'h01;
            state_r <= irb_pkg::ST_SYM_GAP;
          end else if (ploop_r != cfg_r.pkt_loops) begin
            sloop_r <= 8'h00;
            ploop_r <= ploop_r + 8'h01;
            state_r <= irb_pkg::ST_PKT_GAP;
          end else begin
            state_r <= irb_pkg::ST_IDLE;
          end
        end
        irb_pkg::ST_SYM_GAP, irb_pkg::ST_PKT_GAP:
          state_r <= qz_on ? irb_pkg::ST_QZ_LEAD : irb_pkg::ST_PATTERN;
        default: state_r <= irb_pkg::ST_IDLE;
      endcase
    end else if (bit_tick) begin
      cnt_r <= cnt_r + irb_pkg::CNT_W'(1);
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      done_r <= 1'b0;
    end else if (fin) begin
      done_r <= 1'b1;
    end else if (done_clear) begin
      done_r <= 1'b0;
    end
  end

  assign burst_irq = done_r && cfg_r.irq_en;

  // ==========================================================================
  // LED drive
  assign pattern_addr = cnt_r[irb_pkg::ADDR_W-1:0];
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      led_drive_out  <= 1'b0;
      led_drive_oe_n <= 1'b1;
    end else begin
      case (state_r)
        irb_pkg::ST_QZ_LEAD, irb_pkg::ST_QZ_TRAIL: begin
          led_drive_out  <= cfg_r.qz_level;
          led_drive_oe_n <= !qz_on;
        end
        irb_pkg::ST_PATTERN: begin
          led_drive_out  <= pattern_bit;
          led_drive_oe_n <= !(pattern_bit || (cfg_r.qz_level && qz_on));
        end
        default: begin
          led_drive_out  <= 1'b0;
          led_drive_oe_n <= 1'b1;
        end
      endcase
    end
  end

  // ==========================================================================
  // Checks
  property p_wr_gate;
    @(posedge ref_clk) disable iff (!nrst)
    (reg_wr && !burst_mode_enable) |=> $stable(cfg_r);
  endproperty
  a_wr_gate: assert property (p_wr_gate) else $error("write taken off");

  property p_irq_gate;
    @(posedge ref_clk) disable iff (!nrst)
    burst_irq |-> (cfg_r.irq_en && done_r);
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq ungated");

  property p_zero_low;
    @(posedge ref_clk) disable iff (!nrst)
    (state_r == irb_pkg::ST_PATTERN && !pattern_bit && cfg_r.qz_level
     && qz_on && !start && burst_mode_enable)
    |=> (!led_drive_oe_n && !led_drive_out);
  endproperty
  a_zero_low: assert property (p_zero_low) else $error("zero not low");

  property p_qz_level;
    @(posedge ref_clk) disable iff (!nrst)
    (state_r == irb_pkg::ST_QZ_TRAIL)
    |=> (!led_drive_oe_n && led_drive_out == $past(cfg_r.qz_level));
  endproperty
  a_qz_level: assert property (p_qz_level) else $error("quiet lvl");

  property p_gap_off;
    @(posedge ref_clk) disable iff (!nrst)
    (state_r == irb_pkg::ST_SYM_GAP || state_r == irb_pkg::ST_PKT_GAP)
    |=> (!led_drive_out && led_drive_oe_n);
  endproperty
  a_gap_off: assert property (p_gap_off) else $error("gap led on");

  property p_tick_gap;
    @(posedge ref_clk) disable iff (!nrst)
    bit_tick |=> !bit_tick [*8];
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("tick fast");

  property p_start_busy;
    @(posedge ref_clk) disable iff (!nrst)
    start |=> (state_r == (qz_on ? irb_pkg::ST_QZ_LEAD : irb_pkg::ST_PATTERN));
  endproperty
  a_start_busy: assert property (p_start_busy) else $error("no start");

  property p_done_set;
    @(posedge ref_clk) disable iff (!nrst)
    (fin && !start) |=> (done_r && state_r == irb_pkg::ST_IDLE);
  endproperty
  a_done_set: assert property (p_done_set) else $error("done miss");

  property p_pkt_after;
    @(posedge ref_clk) disable iff (!nrst)
    (state_r == irb_pkg::ST_PKT_GAP) |-> (sloop_r == 8'h00
      && ploop_r != 8'h00);
  endproperty
  a_pkt_after: assert property (p_pkt_after) else $error("pkt order");
endmodule : irb_burst_timing

// ==== testbench/irb_pattern_ram.sv ====
`timescale 1ns/100ps
module irb_pattern_ram (
  input  wire logic [irb_pkg::ADDR_W-1:0] addr,  // Bit index
  output logic                            bit_q  // Stored pattern bit
);
  // ==========================================================================
  // Storage, filled by the bench
  logic mem [0:1023];

  // Combinational read, same cycle as address
  assign bit_q = mem[addr];
endmodule : irb_pattern_ram

// ==== testbench/tb_top.sv ====
`timescale 1ns/100ps
module tb_top;
  logic                       ref_clk           = 1'b0;
  logic                       nrst              = 1'b0;
  logic                       burst_mode_enable = 1'b0;
  logic [7:0]                 reg_addr          = 8'h00;
  logic [7:0]                 reg_wdata         = 8'h00;
  logic                       reg_wr            = 1'b0;
  logic                       done_clear        = 1'b0;
  logic [7:0]                 reg_rdata;
  logic                       pattern_bit;
  logic [irb_pkg::ADDR_W-1:0] pattern_addr;
  logic                       led_drive_out;
  logic                       led_drive_oe_n;
  logic                       burst_irq;
  int                         n_errors;
  int                         total_checks;
  int                         seed;
  int                         k;
  logic [1:0]                 exp_q[$];
  logic [7:0]                 got;
  logic [7:0]                 ctrl_v;
  logic [31:0]                r;
  irb_pkg::irb_cfg_t          c;

  always #5 ref_clk = ~ref_clk;

  irb_burst_timing dut_u (
    .ref_clk(ref_clk), .nrst(nrst), .burst_mode_enable(burst_mode_enable),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rdata(reg_rdata), .done_clear(done_clear),
    .pattern_bit(pattern_bit), .pattern_addr(pattern_addr),
    .led_drive_out(led_drive_out), .led_drive_oe_n(led_drive_oe_n),
    .burst_irq(burst_irq));

  irb_pattern_ram ram_u (.addr(pattern_addr), .bit_q(pattern_bit));

  // ==========================================================================
  // Reporting
  task automatic report_and_stop();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : report_and_stop

  task automatic check(input logic [7:0] g, input logic [7:0] e,
                       input string what);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, g, e);
    end
  endtask : check

  // ==========================================================================
  // Register access
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge ref_clk);
    reg_wr    = 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(negedge ref_clk);
    reg_addr = a;
    @(negedge ref_clk);
    d = reg_rdata;
  endtask : rd_reg

  // ==========================================================================
  // Expected LED trace, one entry per cycle
  task automatic push(input logic [1:0] v, input int n);
    repeat (n) exp_q.push_back(v);
  endtask : push

  task automatic build();
    int   bt;
    int   qz;
    logic z;
    bt = irb_pkg::UNIT_CYC * (c.bt_code + 1);
    qz = (c.qz_len == 3'h0) ? 0 : (2 * (1 << c.qz_len) + 1) * bt;
    z  = c.qz_level && (c.qz_len != 3'h0);
    exp_q.delete();
    for (int p = 0; p <= c.pkt_loops; p++) begin
      for (int s = 0; s <= c.sym_loops; s++) begin
        push({c.qz_level, 1'b0}, qz);
        for (int i = 0; i < 4 * (c.nibbles + 1); i++) begin
          push(ram_u.mem[i] ? 2'h2 : {1'b0, ~z}, bt);
        end
        push({c.qz_level, 1'b0}, qz);
        if (s < c.sym_loops) push(2'h1, 2 * (c.sym_gap + 1) * bt);
      end
      if (p < c.pkt_loops) push(2'h1, 4 * (c.pkt_gap + 1) * bt);
    end
    push(2'h1, 3);
  endtask : build

  // ==========================================================================
  // One complete event
  task automatic run();
    ctrl_v = {2'h0, c.irq_en, 1'b0, c.qz_level, c.qz_len};
    wr_reg(irb_pkg::ADDR_CTRL, ctrl_v);
    wr_reg(irb_pkg::ADDR_RSV, 8'h00);
    wr_reg(irb_pkg::ADDR_SLOOP, c.sym_loops);
    wr_reg(irb_pkg::ADDR_SGAP, c.sym_gap);
    wr_reg(irb_pkg::ADDR_PLOOP, c.pkt_loops);
    wr_reg(irb_pkg::ADDR_PGAP, c.pkt_gap);
    wr_reg(irb_pkg::ADDR_BT, {2'h0, c.bt_code});
    rd_reg(irb_pkg::ADDR_CTRL, got);
    check(got, ctrl_v, "ctrl readback");
    rd_reg(irb_pkg::ADDR_BT, got);
    check(got, {2'h0, c.bt_code}, "bit time readback");
    build();
    wr_reg(irb_pkg::ADDR_SLEN, c.nibbles);
    reg_addr = irb_pkg::ADDR_STAT;
    k = 0;
    @(negedge ref_clk);
    while ({led_drive_out, led_drive_oe_n} === 2'h1 && k < 4) begin
      @(negedge ref_clk);
      k++;
    end
    if (k == 4) begin
      n_errors++;
      $display("wrong value at %0t: LED never started", $time);
      report_and_stop();
    end
    for (int i = 0; i < exp_q.size(); i++) begin
      check({6'h0, led_drive_out, led_drive_oe_n}, {6'h0, exp_q[i]},
            "led"); // LED trace
      if (i == exp_q.size() / 2) check(reg_rdata, 8'h01, "busy");
      @(negedge ref_clk);
    end
    rd_reg(irb_pkg::ADDR_STAT, got);
    check(got, 8'h02, "done");
    check({7'h0, burst_irq}, {7'h0, c.irq_en}, "irq");
    done_clear = 1'b1;
    @(negedge ref_clk);
    done_clear = 1'b0;
    rd_reg(irb_pkg::ADDR_STAT, got);
    check(got, 8'h00, "done cleared");
    check({7'h0, burst_irq}, 8'h00, "irq cleared");
  endtask : run

  // ==========================================================================
  // Main sequence
  initial begin
    seed = 32'hA1A3;
    n_errors = 0;
    total_checks = 0;
    for (int i = 0; i < 1024; i++) begin
      ram_u.mem[i] = $random(seed);
    end
    ram_u.mem[0] = 1'b1;
    repeat (6) @(negedge ref_clk);
    nrst = 1'b1;
    burst_mode_enable = 1'b1;
    rd_reg(irb_pkg::ADDR_CTRL, got);
    check(got, 8'h00, "ctrl reset");
    rd_reg(8'hB0, got);
    check(got, 8'h00, "unmapped read");
    c = '0;
    c.qz_len = 3'h7;
    c.qz_level = 1'b1;
    c.irq_en = 1'b1;
    run(); // longest quiet zone
    for (int n = 0; n < 4; n++) begin
      r = $random(seed);
      c = '0;
      c.qz_len = {1'b0, r[1:0]};
      c.bt_code = {5'h0, r[2]};
      c.nibbles = {6'h0, r[4:3]};
      c.sym_loops = {7'h0, r[5]};
      c.pkt_loops = {7'h0, r[7]};
      c.sym_gap = {6'h0, r[9:8]};
      c.pkt_gap = {6'h0, r[11:10]};
      c.qz_level = r[12];
      c.irq_en = r[13];
      run();
    end
    wr_reg(irb_pkg::ADDR_SLEN, 8'h03);
    repeat (40) @(negedge ref_clk);
    burst_mode_enable = 1'b0;
    repeat (3) @(negedge ref_clk);
    check({6'h0, led_drive_out, led_drive_oe_n}, 8'h01, "abort led");
    rd_reg(irb_pkg::ADDR_STAT, got);
    check(got, 8'h00, "abort status");
    wr_reg(irb_pkg::ADDR_CTRL, 8'h2F);
    rd_reg(irb_pkg::ADDR_CTRL, got);
    check(got, ctrl_v, "write with mode off");
    wr_reg(irb_pkg::ADDR_SLEN, 8'h00);
    rd_reg(irb_pkg::ADDR_STAT, got);
    check(got, 8'h00, "start with mode off");
    rd_reg(irb_pkg::ADDR_SLEN, got);
    check(got, 8'h03, "length with mode off");
    report_and_stop();
  end
endmodule : tb_top
